// ===== hw/ivob_defs.svh
// Offsets, field positions, reset values and counts of the vector offset bank.
// Assumes the bank decodes the low 12 bits of a word-aligned AHB-Lite address.
`ifndef IVOB_DEFS_SVH
`define IVOB_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define IVOB_ADDR_W 12
`define IVOB_FLAG_OFF 12'h040
`define IVOB_ENA_OFF 12'h050
`define IVOB_VEC22_OFF 12'h598
`define IVOB_VEC23_OFF 12'h59c
`define IVOB_VEC24_OFF 12'h5a0
`define IVOB_VEC25_OFF 12'h5a4
`define IVOB_VEC26_OFF 12'h5a8
`define IVOB_VEC27_OFF 12'h5ac
`define IVOB_VEC30_OFF 12'h5b8
`define IVOB_VEC31_OFF 12'h5bc
`define IVOB_VEC32_OFF 12'h5c0
`define IVOB_VEC33_OFF 12'h5c4
`define IVOB_VEC35_OFF 12'h5cc
`define IVOB_VEC36_OFF 12'h5d0
`define IVOB_VEC37_OFF 12'h5d4
`define IVOB_VEC38_OFF 12'h5d8
`define IVOB_VEC39_OFF 12'h5dc

// ----------------------------------------------------------------
// Alias displacements of the flag and enable registers
// ----------------------------------------------------------------
`define IVOB_ALIAS_WR 2'h0
`define IVOB_ALIAS_CLR 2'h1
`define IVOB_ALIAS_SET 2'h2
`define IVOB_ALIAS_INV 2'h3

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define IVOB_FIELD_MSB 17
`define IVOB_FIELD_LSB 1
`define IVOB_VEC_COUNT 15
`define IVOB_SRC_COUNT 32
`define IVOB_FIELD_RST 17'h00000
`define IVOB_FLAG_RST 32'h00000000
`define IVOB_ENA_RST 32'h00000000

`endif

// ===== hw/ivob_pkg.sv
// Types shared by the vector offset bank.
// Assumes the constants header is included by the users of these types.
package ivob_pkg;

  // ----------------------------------------------------------------
  // Captured AHB-Lite address phase
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
  } ivob_aphase_t;

endpackage : ivob_pkg

// ===== hw/ivob_bank.sv
// Vector offset bank with interrupt flag and enable registers, AHB-Lite slave.
// Assumes a single master, word transfers only, zero-wait answers.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "ivob_defs.svh"

module ivob_bank #(
  parameter int NVEC = `IVOB_VEC_COUNT,
  parameter int NSRC = `IVOB_SRC_COUNT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NSRC-1:0] periph_en,
  input wire logic [NSRC-1:0] periph_event,
  input wire logic [5:0] vec_num,
  output logic [31:0] vec_offset,
  output logic [NSRC-1:0] int_flags,
  output logic [NSRC-1:0] int_enable
);

  localparam int FW = `IVOB_FIELD_MSB - `IVOB_FIELD_LSB + 1;
  localparam logic [11:0] VEC_ADDR [15] = '{`IVOB_VEC22_OFF, `IVOB_VEC23_OFF, `IVOB_VEC24_OFF,
    `IVOB_VEC25_OFF, `IVOB_VEC26_OFF, `IVOB_VEC27_OFF, `IVOB_VEC30_OFF, `IVOB_VEC31_OFF,
    `IVOB_VEC32_OFF, `IVOB_VEC33_OFF, `IVOB_VEC35_OFF, `IVOB_VEC36_OFF, `IVOB_VEC37_OFF,
    `IVOB_VEC38_OFF, `IVOB_VEC39_OFF};
  localparam logic [5:0] VEC_ID [15] = '{6'h16, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1e, 6'h1f,
    6'h20, 6'h21, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27};
  localparam logic [11:0] FLAG_BASE = `IVOB_FLAG_OFF;
  localparam logic [11:0] ENA_BASE = `IVOB_ENA_OFF;

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  ivob_pkg::ivob_aphase_t aph_r;
  ivob_pkg::ivob_aphase_t aph_nxt;
  wire logic take = hsel && hready && htrans[1];
  assign aph_nxt = '{valid: take, write: hwrite, addr: haddr[11:0]};
  wire logic wr_act = aph_r.valid && aph_r.write;
  wire logic rd_take = take && !hwrite;
  wire logic [11:0] rd_addr = haddr[11:0];

  // ----------------------------------------------------------------
  // Flag and enable registers with aliases
  // ----------------------------------------------------------------
  logic [NSRC-1:0] flags_r;
  logic [NSRC-1:0] flags_nxt;
  logic [NSRC-1:0] ena_r;
  logic [NSRC-1:0] ena_nxt;
  logic [NSRC-1:0] flags_sw;
  logic [NSRC-1:0] ena_sw;
  wire logic [NSRC-1:0] wdat = hwdata[NSRC-1:0];
  wire logic flag_hit = wr_act && (aph_r.addr[11:4] == FLAG_BASE[11:4]);
  wire logic ena_hit = wr_act && (aph_r.addr[11:4] == ENA_BASE[11:4]);
  wire logic [1:0] alias_sel = aph_r.addr[3:2];

  always_comb begin
    unique case (alias_sel)
      `IVOB_ALIAS_CLR: begin
        flags_sw = flags_r & ~wdat;
        ena_sw = ena_r & ~wdat;
      end
      `IVOB_ALIAS_SET: begin
        flags_sw = flags_r | wdat;
        ena_sw = ena_r | wdat;
      end
      `IVOB_ALIAS_INV: begin
        flags_sw = flags_r ^ wdat;
        ena_sw = ena_r ^ wdat;
      end
      `IVOB_ALIAS_WR: begin
        flags_sw = wdat;
        ena_sw = wdat;
      end
    endcase
  end

  // enabled source event sets its flag
  // interrupt enable plays no part here
  // flag only clears by software write; a set wins
  assign flags_nxt = (flag_hit ? flags_sw : flags_r) | (periph_en & periph_event);
  assign ena_nxt = ena_hit ? ena_sw : ena_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= `IVOB_FLAG_RST;
      ena_r <= `IVOB_ENA_RST;
    end else begin
      flags_r <= flags_nxt;
      ena_r <= ena_nxt;
    end
  end

  a_clr_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_act && aph_r.addr == FLAG_BASE + 12'h004 && !(|(periph_en & periph_event))) |=>
    ((flags_r & $past(wdat)) == '0))
    else $error("clear alias left flag bits set");

  a_inv_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_act && aph_r.addr == FLAG_BASE + 12'h00c && !(|(periph_en & periph_event))) |=>
    (flags_r == ($past(flags_r) ^ $past(wdat))))
    else $error("invert alias gave wrong flags");

  a_flag_plain_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_act && aph_r.addr == FLAG_BASE && !(|(periph_en & periph_event))) |=>
    (flags_r == $past(wdat)))
    else $error("plain flag write not stored");

  a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    (flag_hit && alias_sel == `IVOB_ALIAS_CLR && periph_en[2] && periph_event[2]) |=> flags_r[2])
    else $error("clear beat a same-cycle event");

  a_flag_no_stray: assert property (@(posedge hclk) disable iff (!hresetn)
    (!flags_r[3] && !flag_hit && !(periph_en[3] && periph_event[3])) |=> !flags_r[3])
    else $error("flag 3 set without enabled event");

  a_flag_copy: assert property (@(posedge hclk) disable iff (!hresetn)
    int_flags == flags_r)
    else $error("flag output differs from flag state");

  a_ena_set_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_act && aph_r.addr == ENA_BASE + 12'h008) |=> ((ena_r & $past(wdat)) == $past(wdat)))
    else $error("set alias failed to set enable bits");

  a_ena_clr_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_act && aph_r.addr == ENA_BASE + 12'h004) |=> ((ena_r & $past(wdat)) == '0))
    else $error("clear alias left enable bits set");

  a_ena_inv_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_act && aph_r.addr == ENA_BASE + 12'h00c) |=> (ena_r == ($past(ena_r) ^ $past(wdat))))
    else $error("invert alias gave wrong enables");

  a_ena_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !ena_hit |=> (ena_r == $past(ena_r)))
    else $error("enables changed without a write");

  a_ena_copy: assert property (@(posedge hclk) disable iff (!hresetn)
    int_enable == ena_r)
    else $error("enable output differs from enable state");

  // ----------------------------------------------------------------
  // Vector offset registers
  // ----------------------------------------------------------------
  logic [FW-1:0] vector_offset_field_r [NVEC];
  logic [FW-1:0] vector_offset_field_nxt [NVEC];
  logic [NVEC-1:0] rd_vec_hit;
  logic [NVEC-1:0] sel_vec_hit;
  logic [31:0] vec_rd_terms [NVEC];
  logic [31:0] vec_sel_terms [NVEC];

  for (genvar i = 0; i < NVEC; i++) begin : g_vec
    // offset registers have only their own word
    wire logic wr_hit = wr_act && (aph_r.addr == VEC_ADDR[i]);
    // all other bits dropped on write
    assign vector_offset_field_nxt[i] = wr_hit ? hwdata[`IVOB_FIELD_MSB:`IVOB_FIELD_LSB] : vector_offset_field_r[i];
    assign rd_vec_hit[i] = rd_addr == VEC_ADDR[i];
    assign sel_vec_hit[i] = vec_num == VEC_ID[i];
    assign vec_rd_terms[i] = rd_vec_hit[i] ? {14'h0000, vector_offset_field_nxt[i], 1'h0} : 32'h00000000;
    assign vec_sel_terms[i] = sel_vec_hit[i] ? {14'h0000, vector_offset_field_nxt[i], 1'h0} : 32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        vector_offset_field_r[i] <= `IVOB_FIELD_RST;
      end else begin
        vector_offset_field_r[i] <= vector_offset_field_nxt[i];
      end
    end
  end

  logic [31:0] vec_rd_or;
  logic [31:0] vec_sel_or;
  always_comb begin
    vec_rd_or = 32'h00000000;
    vec_sel_or = 32'h00000000;
    for (int i = 0; i < NVEC; i++) begin
      vec_rd_or = vec_rd_or | vec_rd_terms[i];
      vec_sel_or = vec_sel_or | vec_sel_terms[i];
    end
  end

  a_vec_lookup: assert property (@(posedge hclk) disable iff (!hresetn)
    (vec_num == 6'h17) |=> (vec_offset == {14'h0000, vector_offset_field_r[1], 1'h0}))
    else $error("lookup of vector 23 gave wrong offset");

  a_vec_unimpl: assert property (@(posedge hclk) disable iff (!hresetn)
    (vec_num == 6'h1c) |=> (vec_offset == 32'h00000000))
    else $error("unimplemented vector gave nonzero offset");

  a_vec_out_resv: assert property (@(posedge hclk) disable iff (!hresetn)
    (vec_offset[31:18] == 14'h0000 && vec_offset[0] == 1'h0))
    else $error("reserved lookup bits nonzero");

  a_vec_rd_value: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == `IVOB_VEC39_OFF) |=> (hrdata == {14'h0000, vector_offset_field_r[14], 1'h0}))
    else $error("offset read differs from stored field");

  a_vec_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_act |=> (vector_offset_field_r[0] == $past(vector_offset_field_r[0])))
    else $error("offset changed without a write");

  a_vec_no_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_act && aph_r.addr == `IVOB_VEC27_OFF + 12'h004) |=> (vector_offset_field_r[5] == $past(vector_offset_field_r[5])))
    else $error("offset changed through a clear alias");

  a_vec_inv_none: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_act && aph_r.addr == `IVOB_VEC26_OFF + 12'h00c) |=> (vector_offset_field_r[4] == $past(vector_offset_field_r[4])))
    else $error("offset changed through an invert alias");

  // ----------------------------------------------------------------
  // Read data, taken from next values so a write just ahead is seen
  // ----------------------------------------------------------------
  // flags readable at any time
  wire logic rd_flag = rd_addr[11:4] == FLAG_BASE[11:4];
  wire logic rd_ena = rd_addr[11:4] == ENA_BASE[11:4];
  wire logic [31:0] rd_mux = rd_flag ? 32'(flags_nxt) : rd_ena ? 32'(ena_nxt) : vec_rd_or;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_r <= '0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'h1;
      hresp <= 1'h0;
      vec_offset <= 32'h00000000;
      int_flags <= '0;
      int_enable <= '0;
    end else begin
      aph_r <= aph_nxt;
      hrdata <= rd_take ? rd_mux : 32'h00000000;
      hreadyout <= 1'h1;
      hresp <= 1'h0;
      vec_offset <= vec_sel_or;
      int_flags <= flags_nxt;
      int_enable <= ena_nxt;
    end
  end

  a_hready_high: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout == 1'h1)
    else $error("slave inserted a wait state");

  a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hresp == 1'h0)
    else $error("slave answered with an error");

  a_rd_idle_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_take |=> (hrdata == 32'h00000000))
    else $error("read data nonzero outside a read");

  a_ena_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == ENA_BASE) |=> (hrdata == 32'(ena_r)))
    else $error("enable read differs from enable state");

  a_flag_rd_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == FLAG_BASE + 12'h00c) |=> (hrdata == 32'(flags_r)))
    else $error("flag read at alias differs from flag state");

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic seen_clk_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_clk_r <= 1'h0;
    end else begin
      seen_clk_r <= 1'h1;
    end
  end

  a_flag_set_ev: assert property (@(posedge hclk) disable iff (!hresetn)
    (periph_en[0] && periph_event[0]) |=> flags_r[0] && int_flags[0])
    else $error("flag 0 not set by enabled event");
  a_flag_no_ena: assert property (@(posedge hclk) disable iff (!hresetn)
    (!ena_r[1] && periph_en[1] && periph_event[1]) |=> flags_r[1])
    else $error("flag 1 not set while interrupt disabled");
  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (flags_r[0] && !flag_hit) |=> flags_r[0])
    else $error("flag 0 dropped without software clear");
  a_flag_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == `IVOB_FLAG_OFF) |=> hrdata == 32'(flags_r))
    else $error("flag read differs from flag state");
  a_set_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_act && aph_r.addr == (`IVOB_FLAG_OFF + 12'h008)) |=> ((flags_r & $past(wdat)) == $past(wdat)))
    else $error("set alias failed to set flag bits");
  a_vec_resv_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && rd_addr == `IVOB_VEC23_OFF) |=> (hrdata[31:18] == 14'h0000 && hrdata[0] == 1'h0))
    else $error("reserved offset bits read nonzero");
  a_vec_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_act && aph_r.addr == `IVOB_VEC25_OFF) |=> vector_offset_field_r[3] == $past(hwdata[17:1]))
    else $error("offset field not stored from write");
  a_vec_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !seen_clk_r |-> (vector_offset_field_r[0] == `IVOB_FIELD_RST && vector_offset_field_r[14] == `IVOB_FIELD_RST))
    else $error("offset not zero after reset");

endmodule : ivob_bank

// ===== verif/test_ivob_bank.sv
// Self-checking bench of the vector offset bank, driven over AHB-Lite.
// Assumes one slave whose hreadyout is fed back as the bus hready.
`timescale 1ns/10ps
`include "ivob_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_ivob_bank;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, vec_offset, int_flags, int_enable, periph_en = 32'h0, periph_event = 32'h0;
  logic hreadyout, hresp;
  logic [5:0] vec_num = 6'h0;
  logic [31:0] offs[15], flg, ena, rd, d, ev;
  int vecs[15] = '{22, 23, 24, 25, 26, 27, 30, 31, 32, 33, 35, 36, 37, 38, 39};
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #12.5 hclk = ~hclk;
  ivob_bank u_ivob_bank (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .periph_en(periph_en), .periph_event(periph_event),
    .vec_num(vec_num), .vec_offset(vec_offset), .int_flags(int_flags), .int_enable(int_enable));
  // ----------------------------------------------------------------
  // Bus tasks and model helpers
  // ----------------------------------------------------------------
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    `CHK(hresp, 1'b0)
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] x;
    xfer(a, 1'b1, v, x);
  endtask : wr
  function automatic logic [31:0] vaddr(input int v);
    return 32'(`IVOB_VEC22_OFF) + 32'(4 * (v - 22));
  endfunction : vaddr
  function automatic logic [31:0] alias_op(input logic [31:0] m, input int k, input logic [31:0] v);
    case (k)
      0: return v;
      1: return m & ~v;
      2: return m | v;
      default: return m ^ v;
    endcase
  endfunction : alias_op
  task automatic check_offsets();
    for (int i = 0; i < 15; i++) begin
      xfer(vaddr(vecs[i]), 1'b0, 32'h0, rd);
      `CHK(rd, offs[i])
    end
  endtask : check_offsets
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    d = $urandom(88);
    foreach (offs[i]) offs[i] = 32'h0;
    flg = 32'h0;
    ena = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_offsets();
    for (int i = 0; i < 15; i++) begin
      d = $urandom;
      wr(vaddr(vecs[i]), d);
      offs[i] = d & 32'h0003fffe;
    end
    check_offsets();
    for (int i = 0; i < 16; i++) begin
      vec_num <= (i < 15) ? 6'(vecs[i]) : 6'h1c;
      repeat (2) @(posedge hclk);
      `CHK(vec_offset, (i < 15) ? offs[i] : 32'h0)
    end
    wr(32'h5b0, 32'hffffffff);
    wr(32'h5b4, 32'hffffffff);
    wr(32'h5e0, 32'hffffffff);
    xfer(32'h5b0, 1'b0, 32'h0, rd);
    `CHK(rd, 32'h0)
    check_offsets();
    // write, clear, set and invert aliases
    for (int k = 0; k < 8; k++) begin
      d = $urandom;
      wr(((k % 2) ? `IVOB_ENA_OFF : `IVOB_FLAG_OFF) + 32'(4 * (k / 2)), d);
      if (k % 2) ena = alias_op(ena, k / 2, d);
      else flg = alias_op(flg, k / 2, d);
      xfer(`IVOB_FLAG_OFF + 32'hc, 1'b0, 32'h0, rd);
      `CHK(rd, flg)
      xfer(`IVOB_ENA_OFF, 1'b0, 32'h0, rd);
      `CHK(rd, ena)
      `CHK(int_enable, ena)
    end
    // events enabled by periph_en set flags whatever the interrupt enables
    for (int k = 0; k < 6; k++) begin
      periph_en <= $urandom;
      ev = $urandom;
      periph_event <= ev;
      @(posedge hclk);
      periph_event <= 32'h0;
      flg = flg | (periph_en & ev);
      xfer(`IVOB_FLAG_OFF, 1'b0, 32'h0, rd);
      `CHK(rd, flg)
      repeat (3) @(posedge hclk);
      xfer(`IVOB_FLAG_OFF + 32'h4, 1'b0, 32'h0, rd);
      `CHK(rd, flg)
      `CHK(int_flags, flg)
      if (k == 3) begin
        ev = $urandom;
        periph_event <= ev;
        wr(`IVOB_FLAG_OFF + 32'h4, flg | ev);
        periph_event <= 32'h0;
        flg = periph_en & ev;
        xfer(`IVOB_FLAG_OFF, 1'b0, 32'h0, rd);
        `CHK(rd, flg)
      end
    end
    // reset in mid-run clears the bank
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (offs[i]) offs[i] = 32'h0;
    check_offsets();
    xfer(`IVOB_FLAG_OFF, 1'b0, 32'h0, rd);
    `CHK(rd, 32'h0)
    complete_run();
  end
endmodule : test_ivob_bank
